// *** inc/wep_params.svh ***
// Register offsets, field positions, reset values and timing counts of the wake and power controller.
`ifndef WEP_PARAMS_SVH
`define WEP_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WEP_CTRL_OFS      8'h00
`define WEP_WAKE_EN_OFS   8'h04
`define WEP_STATE_OFS     8'h08
`define WEP_SRC_OFS       8'h0c
`define WEP_IRQ_STAT_OFS  8'h10
`define WEP_IRQ_MASK_OFS  8'h14
`define WEP_FAN_OFS       8'h18

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define WEP_CTRL_CMD_LSB    0
`define WEP_CTRL_GO_BIT     2
`define WEP_CTRL_LASTP_BIT  3
`define WEP_CTRL_FORCE_LSB  4
`define WEP_CTRL_LEDDUAL    6

// ----------------------------------------------------------------
// Wake source bit positions (enable, source and status share them)
// ----------------------------------------------------------------
`define WEP_SRC_PWREVT   0
`define WEP_SRC_PCIEWK   1
`define WEP_SRC_USB      2
`define WEP_SRC_KBD      3
`define WEP_SRC_RING     4
`define WEP_SRC_LAN      5
`define WEP_NSRC         6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WEP_WAKE_EN_RST  6'h1f
`define WEP_CTRL_RST     8'h00
`define WEP_FAN_RST      4'hf

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WEP_CLK_HZ         40000000
`define WEP_PWR_SETTLE_US  100
// Divide first: the plain product of hertz and microseconds overflows a 32-bit integer.
`define WEP_PWR_SETTLE_CYC ((`WEP_CLK_HZ / 1000000) * `WEP_PWR_SETTLE_US)

`endif

// *** inc/wep_pkg.sv ***
// Types of the wake and power controller.
package wep_pkg;

	// ----------------------------------------------------------------
	// System sleep states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		WEP_S0,
		WEP_S3,
		WEP_S4,
		WEP_S5,
		WEP_WAKING,
		WEP_SLEEPING
	} wep_state_t;

	// ----------------------------------------------------------------
	// Software sleep commands
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WEP_CMD_S3,
		WEP_CMD_S4,
		WEP_CMD_S5,
		WEP_CMD_NONE
	} wep_cmd_t;

endpackage : wep_pkg

// *** rtl/wep_ctrl.sv ***
// Sleep and wake sequencer with power supply, fan and indicator control.
`timescale 1ns/1ps
`include "wep_params.svh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module wep_ctrl #(
	parameter int NFAN       = 4,
	parameter int SETTLE_CYC = `WEP_PWR_SETTLE_CYC
) (
	// Clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rst_n_i,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// Wake inputs, active low lines and active high activity
	input  wire logic              pwr_event_n_i,
	input  wire logic              pcie_wake_n_i,
	input  wire logic              usb_activity_i,
	input  wire logic              kbd_activity_i,
	input  wire logic              ring_detect_i,
	input  wire logic              modem_irq_unmasked_i,
	input  wire logic              lan_wake_n_i,
	// AC presence and stored power state
	input  wire logic              ac_present_i,
	input  wire logic              last_on_i,
	// Fans
	input  wire logic [NFAN-1:0]   fan_tach_i,
	output logic      [NFAN-1:0]   fan_on_o,
	// Supply, indicator and interrupt
	output logic                   supply_on_o,
	output logic                   led_green_o,
	output logic                   led_amber_o,
	output logic                   last_on_o,
	output logic                   irq_o
);

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic [`WEP_NSRC-1:0] raw_wake;
	logic [`WEP_NSRC-1:0] sync1;
	logic [`WEP_NSRC-1:0] sync2;
	logic [1:0]           ac_sync;
	logic [NFAN-1:0]      tach1;
	logic [NFAN-1:0]      tach2;
	logic [NFAN-1:0]      tach3;

	assign raw_wake = {~lan_wake_n_i, ring_detect_i & modem_irq_unmasked_i, kbd_activity_i,
		usb_activity_i, ~pcie_wake_n_i, ~pwr_event_n_i};

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			sync1   <= '0;
			sync2   <= '0;
			ac_sync <= 2'h0;
		end
		else
		begin
			sync1   <= raw_wake;
			sync2   <= sync1;
			ac_sync <= {ac_sync[0], ac_present_i};
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	wep_pkg::wep_state_t  state;
	wep_pkg::wep_state_t  next_state;
	wep_pkg::wep_state_t  target;
	logic [7:0]           ctrl;
	logic [`WEP_NSRC-1:0] wake_en;
	logic [`WEP_NSRC-1:0] src_flag;
	logic [`WEP_NSRC-1:0] irq_stat;
	logic [`WEP_NSRC-1:0] irq_mask;
	logic [NFAN-1:0]      fan_allow;
	logic [NFAN-1:0]      tach_seen;
	logic [31:0]          settle;
	logic                 saved_on;
	logic                 ac_was;
	logic                 cmd_go;
	logic                 wr;
	logic                 rd;
	logic [`WEP_NSRC-1:0] elig;
	logic [`WEP_NSRC-1:0] hits;
	logic                 wake;
	logic                 asleep;

	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
	assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
	assign cmd_go = wr && wb_adr_i == `WEP_CTRL_OFS && wb_dat_i[`WEP_CTRL_GO_BIT];

	// ----------------------------------------------------------------
	// Wake qualification by state
	// ----------------------------------------------------------------
	always_comb
	begin
		elig = '0;
		case (state)
			wep_pkg::WEP_S3:
			begin
				elig = '1;
			end
			wep_pkg::WEP_S4:
			begin
				elig[`WEP_SRC_PWREVT] = 1'b1;
				elig[`WEP_SRC_PCIEWK] = 1'b1;
				elig[`WEP_SRC_LAN]    = 1'b1;
			end
			wep_pkg::WEP_S5:
			begin
				elig[`WEP_SRC_PWREVT] = wake_en[`WEP_SRC_LAN + 0] & wake_en[`WEP_SRC_PWREVT];
				elig[`WEP_SRC_PCIEWK] = 1'b1;
				elig[`WEP_SRC_LAN]    = wake_en[`WEP_SRC_LAN];
			end
			default:
			begin
				elig = '0;
			end
		endcase
	end

	// The express wake line ignores its enable bit; it has no off switch.
	assign hits = sync2 & elig & (wake_en | (`WEP_NSRC'(1) << `WEP_SRC_PCIEWK));
	assign wake = |hits;
	assign asleep = state == wep_pkg::WEP_S3 || state == wep_pkg::WEP_S4 || state == wep_pkg::WEP_S5;

	// ----------------------------------------------------------------
	// State machine
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			wep_pkg::WEP_S0:
				if (cmd_go && wb_dat_i[1:0] != 2'(wep_pkg::WEP_CMD_NONE))
					next_state = wep_pkg::WEP_SLEEPING;
			wep_pkg::WEP_S3, wep_pkg::WEP_S4, wep_pkg::WEP_S5:
				if (wake)
					next_state = wep_pkg::WEP_WAKING;
			wep_pkg::WEP_WAKING:
				if (settle == 32'h0)
					next_state = wep_pkg::WEP_S0;
			wep_pkg::WEP_SLEEPING:
				next_state = target;
			default:
				next_state = wep_pkg::WEP_S5;
		endcase
		// Power return: stored on/off, unless software forced a response.
		// Decided here so that the supply and indicator registers follow the real next state.
		if (ac_sync[1] && !ac_was)
		begin
			case (ctrl[`WEP_CTRL_FORCE_LSB +: 2])
				2'h1:    next_state = wep_pkg::WEP_WAKING;
				2'h2:    next_state = wep_pkg::WEP_S5;
				default: next_state = saved_on ? wep_pkg::WEP_WAKING : wep_pkg::WEP_S5;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			state  <= wep_pkg::WEP_S5;
			target <= wep_pkg::WEP_S5;
			ac_was <= 1'b0;
		end
		else
		begin
			ac_was <= ac_sync[1];
			state  <= next_state;
			if (cmd_go)
			begin
				case (wb_dat_i[1:0])
					2'(wep_pkg::WEP_CMD_S3): target <= wep_pkg::WEP_S3;
					2'(wep_pkg::WEP_CMD_S4): target <= wep_pkg::WEP_S4;
					default:                  target <= wep_pkg::WEP_S5;
				endcase
			end
		end
	end

	// Settle count gives the rails time before the working state is reported.
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			settle <= 32'h0;
		else if (state != wep_pkg::WEP_WAKING)
			settle <= 32'(SETTLE_CYC);
		else if (settle != 32'h0)
			settle <= settle - 32'h1;
	end

	// Last power state; the stored input, or the LASTP control bit, seeds it while in S5 without AC.
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			saved_on <= 1'b0;
		else if (!ac_sync[1] && ac_was)
			saved_on <= saved_on;
		else if (state == wep_pkg::WEP_S0)
			saved_on <= 1'b1;
		else if (state == wep_pkg::WEP_SLEEPING)
			saved_on <= 1'b0;
		else if (state == wep_pkg::WEP_S5 && !ac_sync[1])
			saved_on <= last_on_i | ctrl[`WEP_CTRL_LASTP_BIT];
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			ctrl      <= `WEP_CTRL_RST;
			wake_en   <= `WEP_WAKE_EN_RST;
			irq_mask  <= '0;
			fan_allow <= NFAN'(`WEP_FAN_RST);
		end
		else if (wr)
		begin
			case (wb_adr_i)
				`WEP_CTRL_OFS:     ctrl      <= wb_dat_i[7:0] & 8'hfb;
				`WEP_WAKE_EN_OFS:  wake_en   <= wb_dat_i[`WEP_NSRC-1:0];
				`WEP_IRQ_MASK_OFS: irq_mask  <= wb_dat_i[`WEP_NSRC-1:0];
				`WEP_FAN_OFS:      fan_allow <= wb_dat_i[NFAN-1:0];
				default:           ctrl      <= ctrl;
			endcase
		end
	end

	// Source record and interrupt status: a new wake beats a clearing write (source) or read (status).
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			src_flag <= '0;
			irq_stat <= '0;
		end
		else
		begin
			if (wr && wb_adr_i == `WEP_SRC_OFS)
				src_flag <= (src_flag & ~wb_dat_i[`WEP_NSRC-1:0]) | (asleep ? hits : '0);
			else if (asleep)
				src_flag <= src_flag | hits;
			if (rd && wb_adr_i == `WEP_IRQ_STAT_OFS)
				irq_stat <= asleep ? hits : '0;
			else if (asleep)
				irq_stat <= irq_stat | hits;
		end
	end

	// ----------------------------------------------------------------
	// Fan tachometer monitor
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NFAN; gi++)
		begin : g_fan
			always_ff @(posedge sys_clk_i)
			begin
				if (!rst_n_i)
				begin
					tach1[gi]     <= 1'b0;
					tach2[gi]     <= 1'b0;
					tach3[gi]     <= 1'b0;
					tach_seen[gi] <= 1'b0;
				end
				else
				begin
					tach1[gi] <= fan_tach_i[gi];
					tach2[gi] <= tach1[gi];
					tach3[gi] <= tach2[gi];
					if (rd && wb_adr_i == `WEP_FAN_OFS)
						tach_seen[gi] <= tach2[gi] & ~tach3[gi];
					else if (tach2[gi] & ~tach3[gi])
						tach_seen[gi] <= 1'b1;
				end
			end
			assign fan_on_o[gi] = (state == wep_pkg::WEP_S0) & fan_allow[gi];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			supply_on_o <= 1'b0;
			led_green_o <= 1'b0;
			led_amber_o <= 1'b0;
		end
		else
		begin
			supply_on_o <= next_state == wep_pkg::WEP_S0 || next_state == wep_pkg::WEP_WAKING;
			led_green_o <= next_state == wep_pkg::WEP_S0;
			led_amber_o <= next_state == wep_pkg::WEP_S3 && ctrl[`WEP_CTRL_LEDDUAL];
		end
	end

	assign last_on_o = saved_on;
	assign irq_o     = |(irq_stat & irq_mask);

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (rd)
			begin
				case (wb_adr_i)
					`WEP_CTRL_OFS:     wb_dat_o <= {24'h0, ctrl};
					`WEP_WAKE_EN_OFS:  wb_dat_o <= 32'(wake_en);
					`WEP_STATE_OFS:    wb_dat_o <= {29'h0, state};
					`WEP_SRC_OFS:      wb_dat_o <= 32'(src_flag);
					`WEP_IRQ_STAT_OFS: wb_dat_o <= 32'(irq_stat);
					`WEP_IRQ_MASK_OFS: wb_dat_o <= 32'(irq_mask);
					`WEP_FAN_OFS:      wb_dat_o <= {16'h0, 8'(tach_seen), 8'(fan_allow)};
					default:           wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

endmodule : wep_ctrl

// *** tb/wep_ctrl_props.sv ***
// Port checker of the wake and power controller.
`timescale 1ns/1ps
`include "wep_params.svh"
module wep_ctrl_props #(
	parameter int NFAN       = 4,
	parameter int SETTLE_CYC = 4
) (
	// Clock, reset and bus
	input wire logic            sys_clk_i,
	input wire logic            rst_n_i,
	input wire logic            wb_cyc_i,
	input wire logic            wb_stb_i,
	input wire logic            wb_we_i,
	input wire logic [7:0]      wb_adr_i,
	input wire logic [3:0]      wb_sel_i,
	input wire logic [31:0]     wb_dat_i,
	input wire logic            wb_ack_o,
	// Wake lines and outputs
	input wire logic            pcie_wake_n_i,
	input wire logic            usb_activity_i,
	input wire logic [NFAN-1:0] fan_on_o,
	input wire logic            supply_on_o,
	input wire logic            led_green_o,
	input wire logic            led_amber_o
);
	// Sync stages, state step and settle give the longest wake path.
	localparam int WAKE_MAX = SETTLE_CYC + 8;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_sleep_go;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `WEP_CTRL_OFS && wb_sel_i[0]
			&& wb_dat_i[`WEP_CTRL_GO_BIT] && wb_dat_i[1:0] != 2'h3 && led_green_o;
	endsequence
	sequence s_usb_in_s3;
		(led_amber_o && usb_activity_i) [*2];
	endsequence

	chk_ack_answer: assert property (s_taken |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_fan_needs_supply: assert property (fan_on_o != '0 |-> supply_on_o)
		else $error("fan on without main supply");
	chk_amber_supply_off: assert property (led_amber_o |-> !supply_on_o && !led_green_o)
		else $error("amber indicator with supply on");
	chk_fan_after_wake: assert property ($rose(supply_on_o) |-> ##[1:WAKE_MAX] fan_on_o == {NFAN{1'b1}})
		else $error("fans not on after wake");
	chk_express_wake: assert property ((!supply_on_o && !pcie_wake_n_i) [*2] |-> ##[1:WAKE_MAX] supply_on_o)
		else $error("express wake ignored");
	chk_usb_wake_s3: assert property (s_usb_in_s3 |-> ##[1:WAKE_MAX] supply_on_o)
		else $error("usb activity did not wake from sleep");
	chk_sleep_cmd_off: assert property (s_sleep_go |-> ##[1:6] !supply_on_o && fan_on_o == '0)
		else $error("sleep command left supply or fans on");
	chk_sleep_stays: assert property (!supply_on_o && pcie_wake_n_i && !usb_activity_i |=> fan_on_o == '0)
		else $error("fans on while asleep");
endmodule : wep_ctrl_props

bind wep_ctrl wep_ctrl_props #(.NFAN(NFAN), .SETTLE_CYC(SETTLE_CYC)) wep_ctrl_props_i (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o), .pcie_wake_n_i(pcie_wake_n_i), .usb_activity_i(usb_activity_i),
	.fan_on_o(fan_on_o), .supply_on_o(supply_on_o), .led_green_o(led_green_o),
	.led_amber_o(led_amber_o));

// *** tb/wep_ctrl_tb.sv ***
// Self-checking bench of the wake and power controller.
`timescale 1ns/1ps
`include "wep_params.svh"
module wep_ctrl_tb;
	localparam logic [31:0] S0 = 32'(wep_pkg::WEP_S0);
	localparam logic [31:0] S3 = 32'(wep_pkg::WEP_S3);
	localparam logic [31:0] S4 = 32'(wep_pkg::WEP_S4);
	localparam logic [31:0] S5 = 32'(wep_pkg::WEP_S5);
	logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hf, bsel = 4'hf;
	logic [31:0] wdat = 32'h0, rdat;
	logic        ack, pev_n, pcw_n, usb, kbd, ring, lan_n, unm = 1'b1, ac = 1'b1, lon = 1'b0;
	logic [5:0]  req = 6'h00;
	logic [3:0]  tach, fan;
	logic        sup, grn, amb, lout, irq, rail;
	int          err_total = 0;
	int          samples_checked = 0;

	always #12.5 sys_clk_i = ~sys_clk_i;

	wep_ctrl #(.NFAN(4), .SETTLE_CYC(4)) wep_ctrl_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .pwr_event_n_i(pev_n), .pcie_wake_n_i(pcw_n),
		.usb_activity_i(usb), .kbd_activity_i(kbd), .ring_detect_i(ring), .modem_irq_unmasked_i(unm),
		.lan_wake_n_i(lan_n), .ac_present_i(ac), .last_on_i(lon), .fan_tach_i(tach), .fan_on_o(fan),
		.supply_on_o(sup), .led_green_o(grn), .led_amber_o(amb), .last_on_o(lout), .irq_o(irq));
	wep_far_side #(.NFAN(4)) wep_far_side_i (.sys_clk_i(sys_clk_i), .wake_req_i(req), .fan_on_i(fan),
		.supply_on_i(sup), .pwr_event_n_o(pev_n), .pcie_wake_n_o(pcw_n), .usb_activity_o(usb),
		.kbd_activity_o(kbd), .ring_detect_o(ring), .lan_wake_n_o(lan_n), .fan_tach_o(tach),
		.rail_main_o(rail));

	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : check

	// Holds the request until the edge that samples ack.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk_i);
		{cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, bsel};
		@(posedge sys_clk_i);
		while (ack !== 1'b1)
			@(posedge sys_clk_i);
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask : wb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		check(q, exp, what);
	endtask : rd

	task wait_state(input logic [31:0] s, input string what);
		logic [31:0] q;
		int          n;
		q = 32'hffffffff;
		n = 0;
		while (q !== s && n < 40)
		begin
			wb(1'b0, `WEP_STATE_OFS, 32'h0, q);
			n++;
		end
		check(q, s, what);
	endtask : wait_state

	task go_sleep(input logic [1:0] cmd, input logic [31:0] s);
		wr(`WEP_CTRL_OFS, 32'h44 | 32'(cmd));
		wait_state(s, "sleep state");
		#1 check({amb, sup, fan}, {s == S3, 5'h0}, "sleep outputs");
	endtask : go_sleep

	task t_reset;
		check({sup, fan, irq}, 6'h0, "reset outputs");
		rd(`WEP_WAKE_EN_OFS, 32'h1f, "wake enable reset");
		bsel = 4'he;
		wr(`WEP_WAKE_EN_OFS, 32'h0);
		bsel = 4'hf;
		rd(`WEP_WAKE_EN_OFS, 32'h1f, "write without lane 0");
		rd(`WEP_STATE_OFS, S5, "reset state");
		wr(8'h1c, 32'hffffffff);
		rd(8'h1c, 32'h0, "unmapped");
		$display("test reset done");
	endtask : t_reset

	task t_lan;
		req <= 6'h20;
		repeat (20) @(posedge sys_clk_i);
		rd(`WEP_STATE_OFS, S5, "lan s5 default");
		req <= 6'h00;
		repeat (4) @(posedge sys_clk_i);
		wr(`WEP_WAKE_EN_OFS, 32'h3f);
		wr(`WEP_IRQ_MASK_OFS, 32'h20);
		req <= 6'h20;
		wait_state(S0, "lan wake");
		req <= 6'h00;
		check({grn, fan, irq}, 6'h3f, "working outputs");
		rd(`WEP_SRC_OFS, 32'h20, "lan source");
		wr(`WEP_SRC_OFS, 32'h20);
		rd(`WEP_SRC_OFS, 32'h0, "source cleared");
		rd(`WEP_IRQ_STAT_OFS, 32'h20, "irq status");
		#1 check(irq, 1'b0, "irq cleared");
		rd(`WEP_FAN_OFS, 32'h0f0f, "tach seen");
		wr(`WEP_FAN_OFS, 32'h5);
		#1 check(fan, 32'h5, "fan switch");
		wr(`WEP_FAN_OFS, 32'hf);
		$display("test lan done");
	endtask : t_lan

	task t_s3_sources;
		for (int b = 0; b < 5; b++)
		begin
			go_sleep(2'h0, S3);
			req <= 6'(1 << b);
			wait_state(S0, "s3 wake");
			req <= 6'h00;
			rd(`WEP_SRC_OFS, 32'(1 << b), "s3 source");
			wr(`WEP_SRC_OFS, 32'h3f);
		end
		$display("test s3 sources done");
	endtask : t_s3_sources

	task t_s4_ring;
		go_sleep(2'h1, S4);
		req <= 6'h0c;
		repeat (20) @(posedge sys_clk_i);
		rd(`WEP_STATE_OFS, S4, "usb and kbd in s4");
		req <= 6'h02;
		wait_state(S0, "express wake s4");
		req <= 6'h00;
		go_sleep(2'h0, S3);
		unm <= 1'b0;
		req <= 6'h10;
		repeat (20) @(posedge sys_clk_i);
		rd(`WEP_STATE_OFS, S3, "masked ring");
		unm <= 1'b1;
		wait_state(S0, "unmasked ring");
		req <= 6'h00;
		$display("test s4 ring done");
	endtask : t_s4_ring

	task t_ac;
		for (int v = 1; v >= 0; v--)
		begin
			go_sleep(2'h2, S5);
			ac <= 1'b0;
			lon <= v[0];
			repeat (4) @(posedge sys_clk_i);
			ac <= 1'b1;
			repeat (30) @(posedge sys_clk_i);
			rd(`WEP_STATE_OFS, v ? S0 : S5, "ac return");
			check(lout, 32'(v[0]), "last state");
			if (v == 1)
				wr(`WEP_SRC_OFS, 32'h3f);
		end
		wr(`WEP_CTRL_OFS, 32'h50);
		ac <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		ac <= 1'b1;
		repeat (30) @(posedge sys_clk_i);
		rd(`WEP_STATE_OFS, S0, "forced on");
		$display("test ac done");
	endtask : t_ac

	initial
	begin
		repeat (6) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_lan();
		t_s3_sources();
		t_s4_ring();
		t_ac();
		complete_run();
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		complete_run();
	end
endmodule : wep_ctrl_tb

// *** tb/wep_far_side.sv ***
// Model of the wake sources, supply and fans beside the controller.
`timescale 1ns/1ps
module wep_far_side #(
	parameter int NFAN = 4
) (
	// Requests from the bench and controller outputs
	input  wire logic            sys_clk_i,
	input  wire logic [5:0]      wake_req_i,
	input  wire logic [NFAN-1:0] fan_on_i,
	input  wire logic            supply_on_i,
	// Lines towards the controller
	output logic                 pwr_event_n_o,
	output logic                 pcie_wake_n_o,
	output logic                 usb_activity_o,
	output logic                 kbd_activity_o,
	output logic                 ring_detect_o,
	output logic                 lan_wake_n_o,
	output logic [NFAN-1:0]      fan_tach_o,
	output logic                 rail_main_o
);
	// The supply keeps only standby when the controller drops its request.
	assign rail_main_o = supply_on_i;
	initial
	begin
		{pwr_event_n_o, pcie_wake_n_o, lan_wake_n_o} = 3'h7;
		{usb_activity_o, kbd_activity_o, ring_detect_o} = 3'h0;
		fan_tach_o = '0;
	end
	always @(posedge sys_clk_i)
	begin
		pwr_event_n_o <= !wake_req_i[0];
		pcie_wake_n_o <= !wake_req_i[1];
		usb_activity_o <= wake_req_i[2];
		kbd_activity_o <= wake_req_i[3];
		ring_detect_o <= wake_req_i[4];
		lan_wake_n_o <= !wake_req_i[5];
		// A fan without power makes no tach edges.
		fan_tach_o <= fan_tach_o ^ (fan_on_i & {NFAN{rail_main_o}});
	end
endmodule : wep_far_side
